/* File: exr_params.svh */
/*
 constants of the explicit receive framer: frame bytes, register offsets, field positions.
 assumes inclusion by bare name from the package; exr_framer uses its macros without including it, exr_buf uses none.
*/
`ifndef EXR_PARAMS_SVH
`define EXR_PARAMS_SVH

`define EXR_START_BYTE 8'h7e
`define EXR_TYPE_BYTE  8'h91
`define EXR_CSUM_BASE  8'hff
`define EXR_FIXED_LEN  16'h0012
`define EXR_HDR_LAST   5'h14
`define EXR_SUM_FIRST  5'h03
`define EXR_OPT_RSVD   8'h0c
`define EXR_OPT_MGMT   0
`define EXR_OPT_EXPL   1

`define EXR_REG_CTRL   4'h0
`define EXR_REG_STATUS 4'h4
`define EXR_REG_FRAMES 4'h8
`define EXR_REG_DROPS  4'hc
`define EXR_CTRL_RST   2'h0

`define EXR_RESP_OKAY   2'h0
`define EXR_RESP_SLVERR 2'h2

`endif

/* File: exr_pkg.sv */
/*
 types of the explicit receive framer: state encoding and the register struct.
 assumes exr_params.svh is on the include path.
*/
`include "exr_params.svh"

package exr_pkg;

	typedef enum logic [2:0] {
		EXR_IDLE = 3'h0,
		EXR_HDR  = 3'h1,
		EXR_PAY  = 3'h3,
		EXR_CSUM = 3'h2,
		EXR_DROP = 3'h6
	} exr_state_t;

	typedef struct packed {
		exr_state_t  st;
		logic [167:0] hdr;
		logic [4:0]   idx;
		logic [15:0]  remain;
		logic [7:0]   sum;
		logic         hv;
		logic [7:0]   hb;
		logic         rx_ready;
		logic         pl_ready;
		logic [1:0]   api_output_options;
		logic [15:0]  frames;
		logic [15:0]  drops;
		logic         awready;
		logic         wready;
		logic         aw_got;
		logic         w_got;
		logic [3:0]   awaddr;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         arready;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
	} exr_regs_t;

endpackage

/* File: exr_buf.sv */
/*
 shift-register byte buffer with valid and ready on both sides; entry 0 is the output.
 assumes one clock and a synchronous active-low reset.
*/
module exr_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	import exr_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [DEPTH-1:0]            vld;
		logic [CW-1:0]               cnt;
	} exr_buf_t;

	exr_buf_t r;
	exr_buf_t n;
	logic     pop;
	logic     push;

	assign in_ready  = (r.cnt != CW'(DEPTH));
	assign out_valid = r.vld[0];
	assign out_data  = r.mem[0];

	always_comb begin
		n    = r;
		pop  = r.vld[0] && out_ready;
		push = in_valid && in_ready;
		// shift down on pop, write at the first free slot
		for (int i = 0; i < DEPTH; i++) begin
			if (pop) begin
				n.mem[i] = (i + 1 < DEPTH) ? r.mem[(i + 1) % DEPTH] : r.mem[i];
				n.vld[i] = (i + 1 < DEPTH) ? r.vld[(i + 1) % DEPTH] : 1'b0;
			end
			if (push && (CW'(i) == (r.cnt - CW'(pop)))) begin
				n.mem[i] = in_data;
				n.vld[i] = 1'b1;
			end
		end
		n.cnt = r.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_full_stall;
		(r.cnt == CW'(DEPTH)) && !out_ready |=> !in_ready;
	endproperty
	a_full_stall: assert property (p_full_stall) else $error("buffer full but ready high");

	property p_hold_out;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("output byte changed while stalled");

endmodule

/* File: exr_framer.sv */
/*
 explicit receive indicator framer with an axi4-lite register slave.
 assumes the radio side offers one metadata word per packet with its payload length,
 then exactly that many payload bytes; the host drains the byte stream with ready.
*/
// Notes on behaviour
// [R01] frames for ordinary packets only when explicit output option bit 1 is set
// [R02] every frame opens with the start byte at position 0
// [R03] two-byte count at position 1: bytes between count and checksum
// [R04] frame type 0x91 at position 3
// [R05] sender long address from position 4, most significant byte first
// [R06] sender short address at position 12
// [R07] source endpoint at 14, destination endpoint at 15
// [R08] cluster at 16, profile at 18
// [R09] receive options byte at position 20
// [R10] bit 0 acknowledged, bit 1 broadcast, bits 2 and 3 reserved zero
// [R11] bit 4 secure session, bit 5 encrypted, bit 6 from end device
// [R12] bits 7:6 carry the delivery method
// [R13] several option flags may be set together
// [R14] payload follows the options byte from position 21 up to the checksum
// [R15] checksum is 0xff minus low byte of sum from position 3 onward
// [R16] management command responses also produce this frame
// [R17] host sets output option bit 0 to receive management responses; the code frames them when either option bit is set
// [R18] management payload stays little-endian, other fields big-endian
// [R19] bytes leave one after another in ascending position order
module exr_framer #(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [3:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [3:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         rx_valid,
	output logic              rx_ready,
	input  wire logic         rx_is_mgmt,
	input  wire logic [63:0]  rx_src_long,
	input  wire logic [15:0]  rx_src_short,
	input  wire logic [7:0]   rx_src_ep,
	input  wire logic [7:0]   rx_dst_ep,
	input  wire logic [15:0]  rx_cluster,
	input  wire logic [15:0]  rx_profile,
	input  wire logic [7:0]   rx_options,
	input  wire logic [15:0]  rx_len,
	input  wire logic         pl_valid,
	input  wire logic [7:0]   pl_data,
	output logic              pl_ready,
	output logic              out_valid,
	output logic [7:0]        out_data,
	input  wire logic         out_ready
);
	import exr_pkg::*;

	exr_regs_t   r;
	exr_regs_t   n;
	logic        buf_in_ready;
	logic        drain;
	logic        slot;
	logic        rx_take;
	logic        pl_take;
	logic        send;
	logic [15:0] cnt;
	logic [7:0]  opts;

	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign rx_ready      = r.rx_ready;
	assign pl_ready      = r.pl_ready;

	// [R19] strict byte order
	exr_buf #(
		.WIDTH (8),
		.DEPTH (BUF_DEPTH)
	) i_exr_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (r.hv),
		.in_data   (r.hb),
		.in_ready  (buf_in_ready),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_ready (out_ready)
	);

	always_comb begin
		n       = r;
		drain   = r.hv && buf_in_ready;
		slot    = !r.hv || drain;
		rx_take = rx_valid && r.rx_ready;
		pl_take = pl_valid && r.pl_ready;
		// [R01] explicit output gate
		// [R16] management responses pass
		send    = rx_is_mgmt ? (r.api_output_options != 2'h0)
			: r.api_output_options[`EXR_OPT_EXPL];
		// [R03] count of bytes
		cnt     = `EXR_FIXED_LEN + rx_len;
		// [R10] reserved bits cleared
		// [R11] flags copied as given
		// [R12] delivery method copied
		// [R13] flags combine freely
		opts    = rx_options & ~`EXR_OPT_RSVD;
		if (drain) begin
			n.hv = 1'b0;
		end
		unique case (r.st)
			EXR_IDLE: begin
				if (rx_take && send) begin
					// [R02] start byte first
					// [R04] type code
					// [R05] long address msb first
					// [R06] short address
					// [R07] endpoints
					// [R08] cluster and profile
					// [R09] options byte last
					// [R18] big-endian header fields
					n.hdr    = {`EXR_START_BYTE, cnt, `EXR_TYPE_BYTE, rx_src_long,
						rx_src_short, rx_src_ep, rx_dst_ep, rx_cluster, rx_profile, opts};
					n.idx    = '0;
					n.sum    = '0;
					n.remain = rx_len;
					n.st     = EXR_HDR;
				end else if (rx_take) begin
					n.drops  = r.drops + 16'h0001;
					n.remain = rx_len;
					if (rx_len != 16'h0000) begin
						n.st = EXR_DROP;
					end
				end
			end
			EXR_HDR: begin
				if (slot) begin
					n.hv  = 1'b1;
					n.hb  = r.hdr[167 -: 8];
					n.hdr = r.hdr << 8;
					n.idx = r.idx + 5'h01;
					// [R15] sum from the type byte on
					if (r.idx >= `EXR_SUM_FIRST) begin
						n.sum = r.sum + r.hdr[167 -: 8];
					end
					if (r.idx == `EXR_HDR_LAST) begin
						n.st = (r.remain == 16'h0000) ? EXR_CSUM : EXR_PAY;
					end
				end
			end
			EXR_PAY: begin
				if (pl_take) begin
					// [R14] payload after options
					// [R18] payload bytes unchanged
					n.hv     = 1'b1;
					n.hb     = pl_data;
					n.sum    = r.sum + pl_data;
					n.remain = r.remain - 16'h0001;
					if (r.remain == 16'h0001) begin
						n.st = EXR_CSUM;
					end
				end
			end
			EXR_CSUM: begin
				if (slot) begin
					// [R15] checksum byte
					n.hv     = 1'b1;
					n.hb     = `EXR_CSUM_BASE - r.sum;
					n.frames = r.frames + 16'h0001;
					n.st     = EXR_IDLE;
				end
			end
			EXR_DROP: begin
				if (pl_take) begin
					n.remain = r.remain - 16'h0001;
					if (r.remain == 16'h0001) begin
						n.st = EXR_IDLE;
					end
				end
			end
			default: begin
				n.st = EXR_IDLE;
			end
		endcase
		n.rx_ready = (n.st == EXR_IDLE);
		n.pl_ready = ((n.st == EXR_PAY) && !n.hv) || (n.st == EXR_DROP);

		// register write channel
		if (s_axi_awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = `EXR_RESP_OKAY;
			if (r.awaddr == `EXR_REG_CTRL) begin
				if (r.wstrb[0]) begin
					n.api_output_options = r.wdata[1:0];
				end
			end else if ((r.awaddr != `EXR_REG_STATUS) && (r.awaddr != `EXR_REG_FRAMES)
				&& (r.awaddr != `EXR_REG_DROPS)) begin
				n.bresp = `EXR_RESP_SLVERR;
			end
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready  = !n.w_got && !n.bvalid;

		// register read channel
		if (s_axi_arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = `EXR_RESP_OKAY;
			unique case (s_axi_araddr)
				`EXR_REG_CTRL:   n.rdata = {30'h0, r.api_output_options};
				`EXR_REG_STATUS: n.rdata = {27'h0, r.hv, r.st, r.st != EXR_IDLE};
				`EXR_REG_FRAMES: n.rdata = {16'h0, r.frames};
				`EXR_REG_DROPS:  n.rdata = {16'h0, r.drops};
				default: begin
					n.rdata = 32'h0;
					n.rresp = `EXR_RESP_SLVERR;
				end
			endcase
		end
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_hdr_load(int k);
		(r.st == EXR_HDR) && slot && (r.idx == 5'(k));
	endsequence

	sequence s_accept_drop;
		rx_take && !send;
	endsequence

	property p_gate;
		s_accept_drop |=> (r.st != EXR_HDR) && (r.hv == $past(r.hv && !buf_in_ready))
			##0 (r.drops == $past(r.drops) + 16'h0001);
	endproperty
	a_gate: assert property (p_gate) else $error("unselected packet produced a frame"); // [R01]

	property p_start;
		s_hdr_load(0) |=> r.hv && (r.hb == `EXR_START_BYTE);
	endproperty
	a_start: assert property (p_start) else $error("frame did not open with start byte"); // [R02]

	property p_count;
		rx_take && send |=> (r.hdr[159:144] == $past(rx_len) + `EXR_FIXED_LEN);
	endproperty
	a_count: assert property (p_count) else $error("count field wrong"); // [R03]

	property p_type;
		s_hdr_load(3) |=> r.hv && (r.hb == `EXR_TYPE_BYTE) && (r.sum == $past(r.sum) + r.hb);
	endproperty
	a_type: assert property (p_type) else $error("type byte or sum start wrong"); // [R04]

	property p_opts;
		rx_take && send |=> (r.hdr[3:2] == 2'h0) && (r.hdr[167 -: 8] == `EXR_START_BYTE);
	endproperty
	a_opts: assert property (p_opts) else $error("reserved option bits set"); // [R10]

	property p_payload;
		pl_take && (r.st == EXR_PAY) |=> r.hv && (r.hb == $past(pl_data));
	endproperty
	a_payload: assert property (p_payload) else $error("payload byte not passed on"); // [R14]

	property p_csum;
		(r.st == EXR_CSUM) && slot |=> r.hv && (r.hb == `EXR_CSUM_BASE - $past(r.sum));
	endproperty
	a_csum: assert property (p_csum) else $error("checksum byte wrong"); // [R15]

	property p_hold;
		r.hv && !buf_in_ready |=> r.hv && $stable(r.hb);
	endproperty
	a_hold: assert property (p_hold) else $error("pending byte lost or changed"); // [R19]

	property p_bresp;
		r.aw_got && r.w_got && !r.bvalid |=> r.bvalid ##0 !r.awready && !r.wready;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response missing");

	property p_long;
		rx_take && send |=> (r.hdr[135:72] == $past(rx_src_long));
	endproperty
	a_long: assert property (p_long) else $error("long address field wrong"); // [R05]

	property p_short;
		rx_take && send |=> (r.hdr[71:56] == $past(rx_src_short));
	endproperty
	a_short: assert property (p_short) else $error("short address field wrong"); // [R06]

	property p_endp;
		rx_take && send |=> (r.hdr[55:48] == $past(rx_src_ep))
			&& (r.hdr[47:40] == $past(rx_dst_ep));
	endproperty
	a_endp: assert property (p_endp) else $error("endpoint fields wrong"); // [R07]

	property p_ids;
		rx_take && send |=> (r.hdr[39:24] == $past(rx_cluster))
			&& (r.hdr[23:8] == $past(rx_profile));
	endproperty
	a_ids: assert property (p_ids) else $error("cluster or profile field wrong"); // [R08]

	property p_mgmt;
		rx_take && rx_is_mgmt && r.api_output_options[`EXR_OPT_MGMT] |=> (r.st == EXR_HDR);
	endproperty
	a_mgmt: assert property (p_mgmt) else $error("management response not framed"); // [R16]

	property p_last;
		s_hdr_load(`EXR_HDR_LAST) |=> r.hv && ((r.hb & `EXR_OPT_RSVD) == 8'h00)
			&& (r.st != EXR_HDR);
	endproperty
	a_last: assert property (p_last) else $error("options byte not last header byte"); // [R09]

	property p_order;
		(r.st == EXR_HDR) |-> !r.pl_ready;
	endproperty
	a_order: assert property (p_order) else $error("payload taken during header"); // [R19]

endmodule

/* File: exr_host_model.sv */
/*
 host side of the serial frame stream: takes bytes with ready and keeps them in order.
 assumes the framer's byte stream on out_valid, out_data and out_ready.
*/
module exr_host_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       slow,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_data,
	output logic            out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic [1:0] cnt = 2'h0;
	always @(posedge aclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got.push_back(out_data);
		cnt <= cnt + 2'h1;
		out_ready <= aresetn && (!slow || cnt == 2'h3);
	end
endmodule

/* File: explicit_rx_indicator_framer_tb.sv */
/*
 self-checking bench of the explicit receive framer.
 assumes exr_framer and exr_host_model are compiled before it.
*/
module explicit_rx_indicator_framer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        rx_valid = 1'b0, rx_is_mgmt = 1'b0, pl_valid = 1'b0;
	logic        rx_ready, pl_ready, out_valid, out_ready;
	logic [63:0] rx_src_long = 64'h0;
	logic [15:0] rx_src_short = 16'h0, rx_cluster = 16'h0, rx_profile = 16'h0, rx_len = 16'h0;
	logic [7:0]  rx_src_ep = 8'h0, rx_dst_ep = 8'h0, rx_options = 8'h0, pl_data = 8'h0, out_data;
	logic [7:0]  pl_q[$], exp_q[$];
	int          n_errors = 0, total_checks = 0;

	always #50 aclk = ~aclk;

	exr_framer i_exr_framer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_ready, .rx_is_mgmt, .rx_src_long,
		.rx_src_short, .rx_src_ep, .rx_dst_ep, .rx_cluster, .rx_profile, .rx_options, .rx_len,
		.pl_valid, .pl_data, .pl_ready, .out_valid, .out_data, .out_ready);
	exr_host_model i_exr_host_model (.aclk, .aresetn, .slow, .out_valid, .out_data, .out_ready);

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(resp));
		@(posedge aclk);
	endtask

	task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk(32'(s_axi_rresp), 32'(resp));
		@(posedge aclk);
	endtask

	task automatic pkt(input logic mg, input logic [63:0] lg, input logic [63:0] rest,
		input logic [7:0] opt, input logic emit);
		logic [7:0]  s;
		logic [15:0] n;
		int          i;
		exp_q.delete();
		exp_q.push_back(8'h91);
		for (i = 7; i >= 0; i--)
			exp_q.push_back(lg[i*8 +: 8]);
		for (i = 7; i >= 0; i--)
			exp_q.push_back(rest[i*8 +: 8]);
		exp_q.push_back(opt & 8'hf3);
		foreach (pl_q[k])
			exp_q.push_back(pl_q[k]);
		s = 8'h0;
		foreach (exp_q[k])
			s += exp_q[k];
		n = 16'(exp_q.size());
		exp_q.push_back(8'hff - s);
		exp_q.push_front(n[7:0]);
		exp_q.push_front(n[15:8]);
		exp_q.push_front(8'h7e);
		rx_is_mgmt <= mg;
		rx_src_long <= lg;
		{rx_src_short, rx_src_ep, rx_dst_ep, rx_cluster, rx_profile} <= rest;
		rx_options <= opt;
		rx_len <= 16'(pl_q.size());
		rx_valid <= 1'b1;
		do @(posedge aclk); while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		foreach (pl_q[k]) begin
			pl_data <= pl_q[k];
			pl_valid <= 1'b1;
			do @(posedge aclk); while (pl_ready !== 1'b1);
		end
		pl_valid <= 1'b0;
		i = 0;
		while (emit && i_exr_host_model.got.size() < exp_q.size() && i < 400) begin
			@(posedge aclk);
			i++;
		end
		repeat (8) @(posedge aclk);
		if (!emit)
			exp_q.delete();
		chk(32'(i_exr_host_model.got.size()), 32'(exp_q.size()));
		foreach (exp_q[k])
			if (k < i_exr_host_model.got.size())
				chk(32'(i_exr_host_model.got[k]), 32'(exp_q[k]));
		i_exr_host_model.got.delete();
		chk(32'(rx_ready), 32'h1);
	endtask

	task automatic t_regs;
		axr(4'h0, 32'h0, 2'h0);
		axr(4'h8, 32'h0, 2'h0);
		axr(4'hc, 32'h0, 2'h0);
		axr(4'h4, 32'h0, 2'h0);
		axw(4'h4, 32'hffffffff, 2'h0);
		axr(4'h4, 32'h0, 2'h0);
		axw(4'h2, 32'h3, 2'h2);
		axr(4'h2, 32'h0, 2'h2);
		axw(4'h0, 32'hffffffff, 2'h0);
		axr(4'h0, 32'h3, 2'h0);
		$display("test regs done");
	endtask

	task automatic t_drop;
		axw(4'h0, 32'h0, 2'h0);
		pl_q = {8'h01, 8'h02};
		pkt(1'b0, 64'h1, 64'h0, 8'h01, 1'b0);
		pkt(1'b1, 64'h4, 64'h0, 8'h01, 1'b0);
		axw(4'h0, 32'h1, 2'h0);
		pkt(1'b0, 64'h2, 64'h0, 8'h02, 1'b0);
		pl_q.delete();
		pkt(1'b0, 64'h3, 64'h0, 8'h00, 1'b0);
		axr(4'hc, 32'h4, 2'h0);
		$display("test drop done");
	endtask

	task automatic t_example;
		axw(4'h0, 32'h2, 2'h0);
		slow <= 1'b1;
		pl_q = {8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
		pkt(1'b0, 64'h0013a20087654321, 64'h87bde8e80011c105, 8'h01,
			1'b1);
		slow <= 1'b0;
		axr(4'h8, 32'h1, 2'h0);
		$display("test example done");
	endtask

	task automatic t_mgmt;
		axw(4'h0, 32'h1, 2'h0);
		pl_q = {8'hb5, 8'h00, 8'h78, 8'h56, 8'h34, 8'h12, 8'h00, 8'ha2, 8'h13, 8'h00,
			8'h6d, 8'h04};
		pkt(1'b1, 64'h0013a20012345678, 64'h046d000080010000, 8'h01,
			1'b1);
		axw(4'h0, 32'h2, 2'h0);
		pkt(1'b1, 64'h0013a20012345678, 64'h046d000080010000, 8'h01,
			1'b1);
		$display("test mgmt done");
	endtask

	task automatic t_opts;
		logic [7:0] ov[6] = '{8'h03, 8'h70, 8'h40, 8'h80, 8'hc0, 8'hff};
		axw(4'h0, 32'h2, 2'h0);
		pl_q.delete();
		foreach (ov[k])
			pkt(1'b0, 64'h8877665544332211, 64'h1234abcd55aa0f0f, ov[k],
				1'b1);
		axr(4'h8, 32'h9, 2'h0);
		$display("test opts done");
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs;
		t_drop;
		t_example;
		t_mgmt;
		t_opts;
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		finish_test;
	end
endmodule
